/* File: hdl/pdm_fifo.sv */
// byte fifo with flush and fill count
module pdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // control and status
  input wire logic flush,
  output logic [CNT_W-1:0] count
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready && !flush;
  assign do_rd = out_valid && out_ready && !flush;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : pdm_fifo

/* File: hdl/pdm_pkg.sv */
// shared constants and types of the packet back end
//
// Overview of operation
// - manchester needs packet mode and enable
// - one sent as 10, zero as 01
// - coding on payload and checksum only
// - one chip rate; manchester halves bits
// - whitening lfsr x9+x5+1
// - whitening xors payload and checksum
// - first line source, receive and standby
// - pattern is address match when filtering
// - second line source, receive and standby
// - transmit start select: start and line
// - transmit second line: full or done
// - first-byte start flushes surplus
// - threshold start keeps surplus queued
// - one packet held until fifo empty
// - packet flags hold until fifo empty
// - checksum status valid when sources fire
// - receive: status clears on fifo emptied
// - emptied in standby: clear on pattern
// - chip state codes
// - data mode codes; upper bit packet
// - failed checksum autoclear flushes, no flags
package pdm_pkg;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_CNT_W = 4;

  // ----------------------------------------------------------------
  // chip state and data mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CHIP_SLEEP = 3'h0;
  localparam logic [2:0] CHIP_STANDBY = 3'h1;
  localparam logic [2:0] CHIP_SYNTH = 3'h2;
  localparam logic [2:0] CHIP_RX = 3'h3;
  localparam logic [2:0] CHIP_TX = 3'h4;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h0;
  localparam logic [1:0] MODE_BUFFERED = 2'h1;
  localparam int MODE_PACKET_BIT = 1;

  // ----------------------------------------------------------------
  // interrupt source selects
  // ----------------------------------------------------------------
  localparam logic [1:0] IRQ0_PAYLOAD = 2'h0;
  localparam logic [1:0] IRQ0_WRITE_BYTE = 2'h1;
  localparam logic [1:0] IRQ0_NOT_EMPTY = 2'h2;
  localparam logic [1:0] IRQ0_PATTERN = 2'h3;
  localparam logic [1:0] IRQ1_CRC_OK = 2'h0;
  localparam logic [1:0] IRQ1_FULL = 2'h1;
  localparam logic [1:0] IRQ1_LEVEL = 2'h2;
  localparam logic [1:0] IRQ1_THRESH = 2'h3;
  localparam logic TX_START_THRESH = 1'b0;
  localparam logic TX_START_FIRST = 1'b1;
  localparam logic TX_IRQ1_FULL = 1'b0;
  localparam logic TX_IRQ1_DONE = 1'b1;

  // ----------------------------------------------------------------
  // coding constants
  // ----------------------------------------------------------------
  localparam int LFSR_W = 9;
  localparam int LFSR_TAP = 5;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 9'h1ff;
  localparam logic [8:0] CRC_BYTES = 9'h002;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] chip_state;
    logic [1:0] data_mode;
    logic manchester_enable;
    logic whitening_enable;
    logic addr_filter_enable;
    logic crc_enable;
    logic crc_autoclear;
    logic [1:0] rx_standby_irq0_select;
    logic [1:0] rx_standby_irq1_select;
    logic tx_start_select;
    logic tx_irq1_select;
    logic [FIFO_CNT_W-1:0] fifo_threshold;
    logic [7:0] payload_length;
    logic [7:0] chip_rate_setting;
  } pdm_cfg_t;

  typedef struct packed {
    logic sync_detect;
    logic addr_match;
    logic crc_match;
    logic signal_level;
  } pdm_rx_evt_t;

  // x^9 + x^5 + 1, shifting toward bit 0; bit 0 is the whitening bit
  function automatic logic [LFSR_W-1:0] pdm_lfsr_step(input logic [LFSR_W-1:0] l);
    pdm_lfsr_step = {l[0] ^ l[LFSR_TAP], l[LFSR_W-1:1]};
  endfunction : pdm_lfsr_step

endpackage : pdm_pkg

/* File: hdl/pdm_top.sv */
// packet back end: dc-free coding, fifo keeping and interrupt mapping
module pdm_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // configuration
  input wire pdm_pkg::pdm_cfg_t CFG,
  // host fifo access
  input wire logic HOST_WR_VALID,
  output logic HOST_WR_READY,
  input wire logic [7:0] HOST_WR_DATA,
  output logic HOST_RD_VALID,
  input wire logic HOST_RD_READY,
  output logic [7:0] HOST_RD_DATA,
  // transmit framer side
  output logic CHIP_TICK,
  output logic TX_START_REQ,
  input wire logic TX_PAYLOAD_GO,
  input wire logic [15:0] TX_CRC,
  output logic TX_CHIP,
  output logic TX_CHIP_VALID,
  // receive modem side
  input wire logic RX_CHIP,
  input wire logic RX_CHIP_VALID,
  input wire pdm_pkg::pdm_rx_evt_t RX_EVT,
  // status and interrupt lines
  output logic CRC_STATUS,
  output logic IRQ0,
  output logic IRQ1
);

  typedef enum logic [2:0] {T_IDLE, T_ARM, T_LEAD, T_SEND, T_DONE} pdm_tx_state_t;
  typedef enum logic [1:0] {R_HUNT, R_BODY, R_HOLD} pdm_rx_state_t;

  // ----------------------------------------------------------------
  // mode decode and fifo
  // ----------------------------------------------------------------
  logic pkt_mode;
  logic in_tx;
  logic in_rx;
  logic in_stby;
  logic manch_on;
  logic white_on;
  assign pkt_mode = CFG.data_mode[pdm_pkg::MODE_PACKET_BIT];
  assign in_tx = pkt_mode && (CFG.chip_state == pdm_pkg::CHIP_TX);
  assign in_rx = pkt_mode && (CFG.chip_state == pdm_pkg::CHIP_RX);
  assign in_stby = pkt_mode && (CFG.chip_state == pdm_pkg::CHIP_STANDBY);
  assign manch_on = pkt_mode && CFG.manchester_enable;
  assign white_on = CFG.whitening_enable;

  pdm_tx_state_t tx_state;
  pdm_rx_state_t rx_state;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic [pdm_pkg::FIFO_CNT_W-1:0] fifo_count;
  logic fifo_flush;
  logic rx_push;
  logic [7:0] rx_byte;
  logic tx_pop;
  logic tx_flush;
  logic rx_flush;
  logic host_wr_ok;
  logic tx_draining;
  logic fifo_empty;
  logic fifo_full;
  logic fifo_thresh;

  assign host_wr_ok = (rx_state != R_BODY) && !rx_push;
  assign tx_draining = (tx_state == T_SEND);
  assign fifo_in_valid = rx_push || (HOST_WR_VALID && host_wr_ok);
  assign fifo_in_data = rx_push ? rx_byte : HOST_WR_DATA;
  assign fifo_out_ready = tx_pop || (HOST_RD_READY && !tx_draining);
  assign fifo_flush = tx_flush || rx_flush;
  assign HOST_WR_READY = host_wr_ok && fifo_in_ready;
  assign HOST_RD_VALID = fifo_out_valid && !tx_draining;
  assign HOST_RD_DATA = fifo_out_data;
  assign fifo_empty = (fifo_count == '0);
  assign fifo_full = !fifo_in_ready;
  assign fifo_thresh = (fifo_count >= CFG.fifo_threshold);

  pdm_fifo #(
    .WIDTH(pdm_pkg::FIFO_WIDTH),
    .DEPTH(pdm_pkg::FIFO_DEPTH),
    .CNT_W(pdm_pkg::FIFO_CNT_W)
  ) u_fifo (
    .clk(CLK),
    .reset_n(RESET_N),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .flush(fifo_flush),
    .count(fifo_count)
  );

  // ----------------------------------------------------------------
  // chip rate divider
  // ----------------------------------------------------------------
  logic [7:0] rate_cnt;
  logic tick;
  assign tick = (rate_cnt == CFG.chip_rate_setting);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rate_cnt <= '0;
      CHIP_TICK <= 1'b0;
    end else begin
      rate_cnt <= tick ? '0 : rate_cnt + 1'b1;
      CHIP_TICK <= tick;
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  logic [7:0] tx_sh;
  logic [2:0] tx_bit;
  logic tx_half;
  logic tx_have;
  logic [8:0] tx_cnt;
  logic [8:0] total_len;
  logic [8:0] len9;
  logic [pdm_pkg::LFSR_W-1:0] tx_lfsr;
  logic tx_done;
  logic tx_start_ok;
  logic tx_b;
  logic tx_bit_end;
  logic tx_need_fifo;

  assign len9 = {1'b0, CFG.payload_length};
  assign total_len = CFG.crc_enable ? len9 + pdm_pkg::CRC_BYTES : len9;
  assign tx_start_ok = (CFG.tx_start_select == pdm_pkg::TX_START_FIRST) ?
                       !fifo_empty : fifo_thresh;
  assign tx_b = tx_sh[7] ^ (white_on && tx_lfsr[0]);
  assign tx_bit_end = tick && tx_have && (tx_half || !manch_on);
  assign tx_need_fifo = (tx_state == T_SEND) && !tx_have && (tx_cnt < len9);
  assign tx_pop = tx_need_fifo && fifo_out_valid;
  assign tx_flush = (tx_state == T_DONE) &&
                    (CFG.tx_start_select == pdm_pkg::TX_START_FIRST);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_state <= T_IDLE;
      TX_START_REQ <= 1'b0;
      tx_done <= 1'b0;
    end else if (!in_tx) begin
      tx_state <= T_IDLE;
      TX_START_REQ <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      case (tx_state)
        T_IDLE: begin
          tx_state <= T_ARM;
        end
        T_ARM: begin
          if (tx_start_ok) begin
            tx_state <= T_LEAD;
            TX_START_REQ <= 1'b1;
          end
        end
        T_LEAD: begin
          if (TX_PAYLOAD_GO) begin
            tx_state <= T_SEND;
            TX_START_REQ <= 1'b0;
            tx_done <= 1'b0;
          end
        end
        T_SEND: begin
          if (!tx_have && tx_cnt == total_len) begin
            tx_state <= T_DONE;
          end
        end
        T_DONE: begin
          tx_done <= 1'b1;
          tx_state <= T_ARM;
        end
        default: begin
          tx_state <= T_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_sh <= '0;
      tx_bit <= '0;
      tx_half <= 1'b0;
      tx_have <= 1'b0;
      tx_cnt <= '0;
      tx_lfsr <= pdm_pkg::LFSR_SEED;
    end else if (tx_state != T_SEND) begin
      tx_bit <= '0;
      tx_half <= 1'b0;
      tx_have <= 1'b0;
      tx_cnt <= '0;
      tx_lfsr <= pdm_pkg::LFSR_SEED;
    end else if (!tx_have) begin
      if (tx_pop) begin
        tx_sh <= fifo_out_data;
        tx_have <= 1'b1;
      end else if (tx_cnt >= len9 && tx_cnt < total_len) begin
        tx_sh <= (tx_cnt == len9) ? TX_CRC[15:8] : TX_CRC[7:0];
        tx_have <= 1'b1;
      end
    end else if (tick) begin
      tx_half <= manch_on && !tx_half;
      if (tx_bit_end) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
        tx_bit <= tx_bit + 1'b1;
        tx_lfsr <= pdm_pkg::pdm_lfsr_step(tx_lfsr);
        if (tx_bit == pdm_pkg::BIT_LAST) begin
          tx_have <= 1'b0;
          tx_cnt <= tx_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_CHIP <= 1'b0;
      TX_CHIP_VALID <= 1'b0;
    end else begin
      TX_CHIP_VALID <= tick && tx_have && (tx_state == T_SEND);
      if (tick && tx_have) begin
        TX_CHIP <= (manch_on && tx_half) ? !tx_b : tx_b;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  logic [7:0] rx_acc;
  logic [2:0] rx_bit;
  logic rx_half;
  logic rx_first;
  logic [8:0] rx_cnt;
  logic [pdm_pkg::LFSR_W-1:0] rx_lfsr;
  logic rx_b;
  logic rx_bit_ok;
  logic rx_byte_end;
  logic [7:0] rx_next_acc;
  logic crc_fail;
  logic payload_ready;
  logic addr_flag;
  logic crc_ok;
  logic sync_evt;

  // pair 10 decodes to one and 01 to zero: the bit is the first chip
  assign rx_bit_ok = RX_CHIP_VALID && (rx_half || !manch_on);
  assign rx_b = (manch_on ? rx_first : RX_CHIP) ^ (white_on && rx_lfsr[0]);
  assign rx_next_acc = {rx_acc[6:0], rx_b};
  assign rx_byte_end = rx_bit_ok && (rx_bit == pdm_pkg::BIT_LAST);
  assign crc_fail = CFG.crc_enable && !RX_EVT.crc_match;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_state <= R_HUNT;
      rx_acc <= '0;
      rx_bit <= '0;
      rx_half <= 1'b0;
      rx_first <= 1'b0;
      rx_cnt <= '0;
      rx_lfsr <= pdm_pkg::LFSR_SEED;
      rx_push <= 1'b0;
      rx_byte <= '0;
      rx_flush <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      rx_flush <= 1'b0;
      case (rx_state)
        R_HUNT: begin
          if (in_rx && fifo_empty && RX_EVT.sync_detect) begin
            rx_state <= R_BODY;
            rx_bit <= '0;
            rx_half <= 1'b0;
            rx_cnt <= '0;
            rx_lfsr <= pdm_pkg::LFSR_SEED;
          end
        end
        R_BODY: begin
          if (!in_rx) begin
            rx_state <= R_HUNT;
            rx_flush <= 1'b1;
          end else if (rx_cnt == total_len) begin
            if (crc_fail && CFG.crc_autoclear) begin
              rx_state <= R_HUNT;
              rx_flush <= 1'b1;
            end else begin
              rx_state <= R_HOLD;
            end
          end else if (RX_CHIP_VALID) begin
            rx_half <= manch_on && !rx_half;
            rx_first <= RX_CHIP;
            if (rx_bit_ok) begin
              rx_acc <= rx_next_acc;
              rx_bit <= rx_bit + 1'b1;
              rx_lfsr <= pdm_pkg::pdm_lfsr_step(rx_lfsr);
              if (rx_byte_end) begin
                rx_cnt <= rx_cnt + 1'b1;
                rx_byte <= rx_next_acc;
                rx_push <= (rx_cnt < len9);
              end
            end
          end
        end
        R_HOLD: begin
          if (fifo_empty) begin
            rx_state <= R_HUNT;
          end
        end
        default: begin
          rx_state <= R_HUNT;
        end
      endcase
    end
  end

  // packet flags
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      payload_ready <= 1'b0;
      addr_flag <= 1'b0;
      crc_ok <= 1'b0;
      CRC_STATUS <= 1'b0;
      sync_evt <= 1'b0;
    end else begin
      sync_evt <= RX_EVT.sync_detect && in_rx;
      if (rx_state == R_BODY && rx_cnt == total_len && in_rx) begin
        if (crc_fail && CFG.crc_autoclear) begin
          addr_flag <= 1'b0;
        end else begin
          payload_ready <= 1'b1;
          crc_ok <= CFG.crc_enable && RX_EVT.crc_match;
          CRC_STATUS <= CFG.crc_enable && RX_EVT.crc_match;
        end
      end else if (rx_state == R_BODY && RX_EVT.addr_match) begin
        addr_flag <= 1'b1;
      end else if (rx_state == R_HOLD && fifo_empty) begin
        payload_ready <= 1'b0;
        addr_flag <= 1'b0;
        crc_ok <= 1'b0;
        if (in_rx) begin
          CRC_STATUS <= 1'b0;
        end
      end else if (rx_state == R_HUNT && in_rx && RX_EVT.sync_detect) begin
        CRC_STATUS <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt mapping
  // ----------------------------------------------------------------
  logic next_irq0;
  logic next_irq1;

  always_comb begin
    next_irq0 = 1'b0;
    next_irq1 = 1'b0;
    if (in_rx) begin
      case (CFG.rx_standby_irq0_select)
        pdm_pkg::IRQ0_PAYLOAD: next_irq0 = payload_ready;
        pdm_pkg::IRQ0_WRITE_BYTE: next_irq0 = rx_push;
        pdm_pkg::IRQ0_NOT_EMPTY: next_irq0 = !fifo_empty;
        pdm_pkg::IRQ0_PATTERN: next_irq0 = CFG.addr_filter_enable ? addr_flag : sync_evt;
        default: next_irq0 = 1'b0;
      endcase
      case (CFG.rx_standby_irq1_select)
        pdm_pkg::IRQ1_CRC_OK: next_irq1 = crc_ok;
        pdm_pkg::IRQ1_FULL: next_irq1 = fifo_full;
        pdm_pkg::IRQ1_LEVEL: next_irq1 = RX_EVT.signal_level;
        pdm_pkg::IRQ1_THRESH: next_irq1 = fifo_thresh;
        default: next_irq1 = 1'b0;
      endcase
    end else if (in_stby) begin
      next_irq0 = (CFG.rx_standby_irq0_select == pdm_pkg::IRQ0_NOT_EMPTY) && !fifo_empty;
      if (CFG.rx_standby_irq1_select == pdm_pkg::IRQ1_FULL) begin
        next_irq1 = fifo_full;
      end else if (CFG.rx_standby_irq1_select == pdm_pkg::IRQ1_THRESH) begin
        next_irq1 = fifo_thresh;
      end
    end else if (in_tx) begin
      next_irq0 = (CFG.tx_start_select == pdm_pkg::TX_START_FIRST) ?
                  !fifo_empty : fifo_thresh;
      next_irq1 = (CFG.tx_irq1_select == pdm_pkg::TX_IRQ1_DONE) ? tx_done : fifo_full;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ0 <= 1'b0;
      IRQ1 <= 1'b0;
    end else begin
      IRQ0 <= next_irq0;
      IRQ1 <= next_irq1;
    end
  end

endmodule : pdm_top

/* File: tb/pdm_framer_model.sv */
// framer model: answers start requests, gathers chips
module pdm_framer_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // block side
  input wire logic start_req,
  output logic payload_go,
  output logic [15:0] crc,
  input wire logic chip,
  input wire logic chip_valid,
  // gathered chips
  output logic [15:0] chips,
  output logic [4:0] nchip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  logic slow;
  logic sent;
  assign crc = 16'hc3a5;
  // -----------------------------------------
  // start handshake
  // -----------------------------------------
  // one go per request, prompt and slow in turn
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      payload_go <= 1'b0;
      sent <= 1'b0;
      slow <= 1'b0;
      wait_cnt <= 4'h0;
    end else begin
      payload_go <= 1'b0;
      if (!start_req) begin
        sent <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (!sent && wait_cnt == (slow ? 4'h6 : 4'h1)) begin
        payload_go <= 1'b1;
        sent <= 1'b1;
        slow <= ~slow;
      end else if (!sent) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
  // -----------------------------------------
  // chip capture
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chips <= 16'h0;
      nchip <= 5'h0;
    end else if (payload_go) begin
      chips <= 16'h0;
      nchip <= 5'h0;
    end else if (chip_valid) begin
      chips <= {chips[14:0], chip};
      nchip <= nchip + 5'h1;
    end
  end
endmodule : pdm_framer_model

/* File: tb/pdm_top_asserts.sv */
// port checks of the packet back end
module pdm_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // watched ports
  input wire pdm_pkg::pdm_cfg_t CFG,
  input wire logic HOST_WR_READY,
  input wire logic HOST_RD_VALID,
  input wire logic TX_PAYLOAD_GO,
  input wire logic TX_CHIP,
  input wire logic TX_CHIP_VALID,
  input wire pdm_pkg::pdm_rx_evt_t RX_EVT,
  input wire logic CHIP_TICK,
  input wire logic CRC_STATUS,
  input wire logic IRQ0,
  input wire logic IRQ1
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic stby;
  logic rx;
  logic tx;
  logic ph;
  logic c0;
  assign stby = CFG.data_mode[1] && CFG.chip_state == pdm_pkg::CHIP_STANDBY;
  assign rx = CFG.data_mode[1] && CFG.chip_state == pdm_pkg::CHIP_RX;
  assign tx = CFG.data_mode[1] && CFG.chip_state == pdm_pkg::CHIP_TX;
  // chip pair phase and first chip of the pair
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ph <= 1'b0;
      c0 <= 1'b0;
    end else if (TX_PAYLOAD_GO) begin
      ph <= 1'b0;
    end else if (TX_CHIP_VALID) begin
      ph <= ~ph;
      c0 <= TX_CHIP;
    end
  end
  logic [1:0] s0, s1;
  assign s0 = CFG.rx_standby_irq0_select;
  assign s1 = CFG.rx_standby_irq1_select;
  chk_irq0_stby_fill: assert property (stby && s0 == 2'h2 && $stable(CFG)
    |-> IRQ0 == $past(HOST_RD_VALID)) else $error("irq0 fill");
  chk_irq0_stby_quiet: assert property (stby && s0 != 2'h2 && $stable(CFG) |-> !IRQ0)
    else $error("irq0 quiet");
  chk_irq1_stby_quiet: assert property (stby && !s1[0] && $stable(CFG) |-> !IRQ1)
    else $error("irq1 quiet");
  chk_irq1_stby_full: assert property (stby && s1 == 2'h1 && $stable(CFG)
    |-> IRQ1 == $past(!HOST_WR_READY)) else $error("irq1 full");
  chk_irq1_rx_level: assert property (rx && s1 == 2'h2 && $stable(CFG)
    |-> IRQ1 == $past(RX_EVT.signal_level)) else $error("irq1 level");
  chk_irq1_tx_full: assert property (tx && !CFG.tx_irq1_select && $stable(CFG)
    |-> IRQ1 == $past(!HOST_WR_READY)) else $error("irq1 tx full");
  chk_man_pair_inv: assert property (tx && CFG.manchester_enable && TX_CHIP_VALID && ph
    |-> TX_CHIP != c0) else $error("bad chip pair");
  chk_flag_hold: assert property (rx && s0 == 2'h0 && $stable(CFG) && IRQ0
    && HOST_RD_VALID |=> IRQ0) else $error("flag dropped");
  chk_crc_clear: assert property (rx && $fell(HOST_RD_VALID) && $stable(CFG)
    |-> ##[0:2] !CRC_STATUS) else $error("crc status kept");
  chk_tick_gap: assert property (CHIP_TICK && CFG.chip_rate_setting == 8'h01
    && $stable(CFG) |=> !CHIP_TICK) else $error("tick too close");
  cov_tx_done: cover property (tx && CFG.tx_irq1_select && IRQ1);
  cov_crc_ok: cover property ($rose(CRC_STATUS));
  cov_man_pair: cover property (tx && CFG.manchester_enable && TX_CHIP_VALID && ph);
endmodule : pdm_chk

bind pdm_top pdm_chk u_chk (.*);

/* File: tb/pdm_top_tb.sv */
// bench for the packet back end
module pdm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET_N, wr_v, wr_r, rd_v, rd_r, req, go, tx_c, tx_v, rx_c, rx_v, crc_st, irq0, irq1;
  logic [7:0] wr_d, rd_d;
  logic [15:0] crc, chips;
  logic [4:0] nchip;
  pdm_pkg::pdm_cfg_t cfg;
  pdm_pkg::pdm_rx_evt_t evt;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  pdm_top dut (.CLK(CLK), .RESET_N(RESET_N), .CFG(cfg), .HOST_WR_VALID(wr_v),
    .HOST_WR_READY(wr_r), .HOST_WR_DATA(wr_d), .HOST_RD_VALID(rd_v), .HOST_RD_READY(rd_r),
    .HOST_RD_DATA(rd_d), .CHIP_TICK(), .TX_START_REQ(req), .TX_PAYLOAD_GO(go), .TX_CRC(crc),
    .TX_CHIP(tx_c), .TX_CHIP_VALID(tx_v), .RX_CHIP(rx_c), .RX_CHIP_VALID(rx_v), .RX_EVT(evt),
    .CRC_STATUS(crc_st), .IRQ0(irq0), .IRQ1(irq1));
  pdm_framer_model fm (.clk(CLK), .reset_n(RESET_N), .start_req(req), .payload_go(go),
    .crc(crc), .chip(tx_c), .chip_valid(tx_v), .chips(chips), .nchip(nchip));
  // -----------------------------------------
  // clock and watchdog
  // -----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // -----------------------------------------
  // access tasks
  // -----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b);
    wr_v <= 1'b1;
    wr_d <= b;
    do @(posedge CLK); while (wr_r !== 1'b1);
    wr_v <= 1'b0;
    @(posedge CLK);
  endtask : wr
  task automatic rd(input logic [7:0] e);
    rd_r <= 1'b1;
    do @(posedge CLK); while (rd_v !== 1'b1);
    chk("read data", rd_d, e);
    rd_r <= 1'b0;
    @(posedge CLK);
  endtask : rd
  // idle chip line shows the inverse
  task automatic send_chip(input logic x);
    rx_c <= x;
    rx_v <= 1'b1;
    @(posedge CLK);
    rx_v <= 1'b0;
    rx_c <= ~x;
    @(posedge CLK);
  endtask : send_chip
  task automatic rx_byte(input logic m, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_chip(b[i]);
      if (m)
        send_chip(~b[i]);
    end
  endtask : rx_byte
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic tx_run(input logic m, w, s, input logic [7:0] b);
    logic [15:0] e;
    logic [8:0] l;
    logic x;
    int n;
    e = 16'h0;
    l = 9'h1ff;
    for (int i = 7; i >= 0; i--) begin
      x = b[i] ^ (w & l[0]);
      l = {l[0] ^ l[5], l[8:1]};
      e = m ? {e[13:0], x, ~x} : {e[14:0], x};
    end
    cfg.manchester_enable <= m;
    cfg.whitening_enable <= w;
    cfg.tx_start_select <= s;
    wr(b);
    wr(~b);
    cfg.chip_state <= 3'h4;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (irq1 !== 1'b1 && n < 400);
    chk("tx done", irq1, 1'b1);
    chk("tx chips", chips, e);
    chk("tx chip count", {11'h0, nchip}, m ? 16'h10 : 16'h08);
    repeat (2) @(posedge CLK);
    chk("surplus kept", rd_v, !s);
    cfg.tx_irq1_select <= 1'b0;
    repeat (3) @(posedge CLK);
    chk("tx irq1 full", irq1, 1'b0);
    cfg.tx_irq1_select <= 1'b1;
    cfg.chip_state <= 3'h1;
    if (!s)
      rd(~b);
    $display("test tx %0d%0d%0d done", m, w, s);
  endtask : tx_run
  task automatic rx_pkt(input logic m, c, input logic [7:0] b);
    cfg.manchester_enable <= m;
    cfg.whitening_enable <= 1'b0;
    cfg.crc_enable <= c;
    cfg.chip_state <= 3'h3;
    // second packet refused while first unread
    for (int k = 0; k < 2; k++) begin
      evt.sync_detect <= 1'b1;
      @(posedge CLK);
      evt.sync_detect <= 1'b0;
      rx_byte(m, b ^ {8{k[0]}});
      if (c) begin
        rx_byte(m, 8'h12);
        rx_byte(m, 8'h34);
      end
      repeat (3) @(posedge CLK);
      chk("payload irq", irq0, 1'b1);
      chk("crc status", crc_st, c);
      if (c)
        chk("crc ok irq", irq1, 1'b1);
    end
    rd(b);
    repeat (3) @(posedge CLK);
    chk("payload irq", irq0, 1'b0);
    chk("crc status", crc_st, 1'b0);
    chk("fifo empty", rd_v, 1'b0);
    $display("test rx %0d%0d done", m, c);
  endtask : rx_pkt
  initial begin
    cfg = '0;
    cfg.chip_state = 3'h1;
    cfg.data_mode = 2'h2;
    cfg.fifo_threshold = 4'h2;
    cfg.payload_length = 8'h01;
    cfg.chip_rate_setting = 8'h01;
    cfg.tx_irq1_select = 1'b1;
    cfg.crc_autoclear = 1'b1;
    evt = '0;
    evt.crc_match = 1'b1;
    {wr_v, wr_d, rd_r, rx_c, rx_v, RESET_N} = '0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    chk("rd valid", rd_v, 1'b0);
    chk("wr ready", wr_r, 1'b1);
    for (int i = 0; i < 8; i++)
      wr(8'h10 + i[7:0]);
    chk("wr ready", wr_r, 1'b0);
    cfg.rx_standby_irq1_select <= 2'h1;
    repeat (3) @(posedge CLK);
    chk("full irq", irq1, 1'b1);
    for (int i = 0; i < 8; i++)
      rd(8'h10 + i[7:0]);
    $display("test fill drain done");
    wr(8'h5a);
    wr(8'ha5);
    for (int s = 0; s < 4; s++) begin
      cfg.rx_standby_irq0_select <= s[1:0];
      cfg.rx_standby_irq1_select <= s[1:0];
      repeat (3) @(posedge CLK);
      chk("stby irq0", irq0, s == 2);
      chk("stby irq1", irq1, s == 3);
    end
    cfg.rx_standby_irq0_select <= 2'h0;
    cfg.rx_standby_irq1_select <= 2'h0;
    rd(8'h5a);
    rd(8'ha5);
    $display("test irq map done");
    tx_run(1'b0, 1'b0, 1'b1, 8'h96);
    tx_run(1'b1, 1'b0, 1'b1, 8'h3c);
    tx_run(1'b0, 1'b1, 1'b1, 8'hf0);
    tx_run(1'b0, 1'b0, 1'b0, 8'h81);
    cfg.chip_state <= 3'h3;
    cfg.rx_standby_irq1_select <= 2'h2;
    evt.signal_level <= 1'b1;
    repeat (3) @(posedge CLK);
    chk("level irq", irq1, 1'b1);
    cfg.rx_standby_irq1_select <= 2'h0;
    evt.signal_level <= 1'b0;
    repeat (3) @(posedge CLK);
    rx_pkt(1'b0, 1'b0, 8'hc5);
    rx_pkt(1'b1, 1'b1, 8'h4b);
    report_and_stop();
  end
endmodule : pdm_top_tb
